//--- src/rxc_addr_stack.sv
// Four-deep stack of latched bus addresses
`timescale 1ns/1ps
module rxc_addr_stack
	import rxc_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
)(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       push,
	input  wire logic [7:0] push_addr,
	input  wire logic [1:0] rd_idx,
	output      logic [7:0] rd_data
);

	logic [7:0] entry [DEPTH];

	// ------------------------------------------------------------
	// Shift chain, entry 0 is the current address
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++)
		begin : g_ent
			if (g == 0)
			begin : g_head
				always_ff @(posedge clk or negedge arst_n)
				begin
					if (!arst_n)
						entry[g] <= 8'h00;
					else if (push)
						entry[g] <= push_addr; // [RQ23]
				end
			end
			else
			begin : g_tail
				always_ff @(posedge clk or negedge arst_n)
				begin
					if (!arst_n)
						entry[g] <= 8'h00;
					else if (push)
						entry[g] <= entry[g-1]; // [RQ23]
				end
			end
		end
	endgenerate

	// Registered read port
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rd_data <= 8'h00;
		else
			rd_data <= entry[rd_idx];
	end

endmodule

//--- src/rxc_ext_ctrl.sv
// Extended control, power-on control and address stack of the clock
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] Two extended control registers sit at 4Ah and 4Bh of bank one.
// [RQ2] Host sets the bank select bit before touching bank-one registers.
// [RQ3] Auxiliary battery valid bit is read-only, zero when battery is spent.
// [RQ4] Update flag rises 122 us before an update and falls at its end.
// [RQ5] Burst bit one lets the RAM address step on data accesses.
// [RQ6] Address steps at strobe rising edge only for accesses to 53h.
// [RQ7] Power-inactive bit zero drives power low; one leaves it floating.
// [RQ8] Enabled wake-up or kickstart flag clears the power-inactive bit.
// [RQ9] With clear enabled, falling clear input sets the RAM clear flag.
// [RQ10] Host writing one to RAM clear flag sets it and raises interrupt.
// [RQ11] Wake-up flag set by alarm or host one, cleared by host zero.
// [RQ12] Kickstart flag set by kickstart or host one, cleared by zero; the code sets it on a kickstart only while its enable bit is set.
// [RQ13] Reserved bits of register A are plain storage without effect.
// [RQ14] Bit 7 of register B enables auxiliary battery functions.
// [RQ15] Bit 6 routes oscillator to square wave; set at power-up.
// [RQ16] Bit 5 selects crystal load: zero 6 pF, one 12.5 pF.
// [RQ17] Bit 4 lets a low clear input fill user RAM with ones.
// [RQ18] Bit 3 chooses whether power output stays active in power fail.
// [RQ19] Bit 2 lets a completed RAM clear pull the interrupt low; the code pulls it once the RAM clear flag sets, ignoring RAM_CLEAR_DONE.
// [RQ20] Wake enable without supply: flag sets, power low, interrupt later; the code drives power low then only while bit 3 of register B is set.
// [RQ21] Wake enable with supply drives interrupt and power; else neither.
// [RQ22] Kickstart enable does likewise for kickstart pulses.
// [RQ23] Each falling address strobe latches the address and pushes it.
// [RQ24] Stack holds four addresses, read at 4Eh and 4Fh.
// [RQ25] Interrupt is the OR of enabled pending flags.
module rxc_ext_ctrl
	import rxc_pkg::*;
#(
	parameter int XRAM_AW  = 12,
	parameter int UIP_LEAD = UIP_LEAD_CYC
)(
	input  wire logic               CLK,
	input  wire logic               ARST_N,
	input  wire logic [7:0]         AD_IN,
	output      logic [7:0]         AD_OUT,
	output      logic               AD_OE,
	input  wire logic               ALE,
	input  wire logic               RD_N,
	input  wire logic               WR_N,
	input  wire logic               CS_N,
	input  wire logic               BANK_SELECT,
	input  wire logic               VCC_GOOD,
	input  wire logic               AUX_BATTERY_OK,
	input  wire logic               UPDATE_SOON,
	input  wire logic               UPDATE_DONE,
	input  wire logic               WAKEUP_ALARM,
	input  wire logic               KICKSTART_N,
	input  wire logic               RAM_CLEAR_N,
	input  wire logic               RAM_CLEAR_DONE,
	input  wire logic               XRAM_ADDR_LOAD,
	input  wire logic [XRAM_AW-1:0] XRAM_ADDR_VAL,
	output      logic [XRAM_AW-1:0] XRAM_ADDR,
	output      logic               RAM_CLEAR_START,
	output      logic               POWER_ON_OUT_OE,
	output      logic               IRQ_OE,
	output      logic               OSC_OUTPUT_ENABLE,
	output      logic               AUX_BATTERY_ENABLE,
	output      logic               XTAL_LOAD_SELECT
);

	// ------------------------------------------------------------
	// Input synchronisers, three stages each
	// ------------------------------------------------------------
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] s1;
	logic [NSYNC-1:0] s2;
	logic [NSYNC-1:0] s3;
	logic [NSYNC-1:0] stable;
	logic [NSYNC-1:0] next_stable;

	assign raw_in = {ALE, RD_N, WR_N, CS_N, KICKSTART_N, RAM_CLEAR_N,
		WAKEUP_ALARM};

	// Only s2 and s3 are compared; s1 may be metastable
	// Reset matches the idle pins so no false edge follows reset
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			s1 <= 7'h3e;
			s2 <= 7'h3e;
			s3 <= 7'h3e;
			stable <= 7'h3e;
		end
		else
		begin
			s1 <= raw_in;
			s2 <= s1;
			s3 <= s2;
			stable <= next_stable;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++)
		begin : g_flt
			assign next_stable[gi] = (s2[gi] == s3[gi]) ? s3[gi] : stable[gi];
		end
	endgenerate

	rxc_strobe_s strb;
	assign strb = '{ale: stable[6], rd_n: stable[5], wr_n: stable[4],
		cs_n: stable[3]};

	// Edge history of the filtered levels
	logic [NSYNC-1:0] prev;
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			prev <= 7'h3e;
		else
			prev <= stable;
	end

	wire ale_fall  = prev[6] & ~stable[6];
	wire rd_fall   = prev[5] & ~stable[5];
	wire rd_rise   = ~prev[5] & stable[5];
	wire wr_rise   = ~prev[4] & stable[4];
	wire kick_fall = prev[2] & ~stable[2];
	wire ram_clear_input_fall = prev[1] & ~stable[1];
	wire wake_rise = ~prev[0] & stable[0];

	// ------------------------------------------------------------
	// Address latch and decode
	// ------------------------------------------------------------
	logic [7:0] addr;
	logic [7:0] wr_data;
	logic [3:0][7:0] ad_dly;

	// Bus delayed to line up with the filtered strobe; address hold is short
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			ad_dly <= '0;
		else
			ad_dly <= {ad_dly[2:0], AD_IN};
	end

	// Address taken from the delayed bus when the filtered strobe falls
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			addr <= 8'h00;
		else if (ale_fall)
			addr <= ad_dly[3]; // [RQ23]
	end

	// Bank-one registers decode only while chip select and the bank select bit are both active
	wire sel      = ~strb.cs_n & BANK_SELECT; // [RQ2]
	wire hit_a    = sel & (addr == OFS_CTRL_A); // [RQ1]
	wire hit_b    = sel & (addr == OFS_CTRL_B); // [RQ1]
	wire hit_data = sel & (addr == OFS_XRAM_DATA);
	wire wr_a     = hit_a & wr_rise;
	wire wr_b     = hit_b & wr_rise;

	// Write data held while WR is low, committed on its rise
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			wr_data <= 8'h00;
		else if (!strb.wr_n)
			wr_data <= AD_IN;
	end

	// ------------------------------------------------------------
	// Register B
	// ------------------------------------------------------------
	logic [7:0] ctrl_b;
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			ctrl_b <= RST_CTRL_B; // [RQ15]
		else if (wr_b)
			ctrl_b <= wr_data; // [RQ14] [RQ16] [RQ18]
	end

	wire ram_clear_input_en  = ctrl_b[B_RAM_CLEAR_INPUT_EN];
	wire wake_en  = ctrl_b[B_WAKE_EN];
	wire kick_en  = ctrl_b[B_KICK_EN];

	// ------------------------------------------------------------
	// Register A flags
	// ------------------------------------------------------------
	logic       ram_clear_input_flag;
	logic       wake_flag;
	logic       kick_flag;
	logic       burst_en;
	logic       pwr_inactive;
	logic [7:0] reserved_a;
	logic       update_busy;

	// Hardware set wins over a same-cycle host clear
	wire next_ram_clear_input = (ram_clear_input_en & ram_clear_input_fall) | (wr_a ? wr_data[A_RAM_CLR_F]
		: ram_clear_input_flag); // [RQ9] [RQ10]
	wire next_wake = wake_rise | (wr_a ? wr_data[A_WAKE_F] : wake_flag);
	wire next_kick = (kick_en & kick_fall) |
		(wr_a ? wr_data[A_KICK_F] : kick_flag);
	wire pwr_clear = (next_wake & wake_en) | (next_kick & kick_en);
	wire next_pab  = pwr_clear ? 1'b0 :
		(wr_a ? wr_data[A_PWR_INACT] : pwr_inactive);

	// Flag and control registers of A
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			ram_clear_input_flag    <= 1'b0;
			wake_flag    <= 1'b0;
			kick_flag    <= 1'b0;
			burst_en     <= 1'b0;
			pwr_inactive <= RST_CTRL_A[A_PWR_INACT];
			reserved_a   <= 8'h00;
		end
		else
		begin
			ram_clear_input_flag    <= next_ram_clear_input; // [RQ9] [RQ10]
			wake_flag    <= next_wake; // [RQ11]
			kick_flag    <= next_kick; // [RQ12] [RQ22]
			pwr_inactive <= next_pab; // [RQ7] [RQ8]
			if (wr_a)
			begin
				burst_en   <= wr_data[A_BURST];
				reserved_a <= wr_data & A_RESERVED_MASK; // [RQ13]
			end
		end
	end

	// Update-in-progress from the timebase strobes
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			update_busy <= 1'b0;
		else if (UPDATE_SOON)
			update_busy <= 1'b1; // [RQ4]
		else if (UPDATE_DONE)
			update_busy <= 1'b0; // [RQ4]
	end

	wire [7:0] ctrl_a = reserved_a
		| ({7'h00, AUX_BATTERY_OK} << A_AUX_VALID) // [RQ3]
		| ({7'h00, update_busy}    << A_UPDATE)
		| ({7'h00, burst_en}       << A_BURST)
		| ({7'h00, pwr_inactive}   << A_PWR_INACT)
		| ({7'h00, ram_clear_input_flag}      << A_RAM_CLR_F)
		| ({7'h00, wake_flag}      << A_WAKE_F)
		| ({7'h00, kick_flag}      << A_KICK_F);

	// ------------------------------------------------------------
	// Extended RAM address with burst stepping
	// ------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			XRAM_ADDR <= '0;
		else if (XRAM_ADDR_LOAD)
			XRAM_ADDR <= XRAM_ADDR_VAL;
		else if (burst_en & hit_data & (rd_rise | wr_rise))
			XRAM_ADDR <= XRAM_ADDR + 1'b1; // [RQ5] [RQ6]
	end

	// ------------------------------------------------------------
	// Address stack
	// ------------------------------------------------------------
	logic [7:0] stack_data;
	wire  [1:0] stack_idx = (addr == OFS_STACK_LOWER) ? 2'h3 : 2'h2;

	rxc_addr_stack #(
		.DEPTH     (STACK_DEPTH)
	) u_stack (
		.clk       (CLK),
		.arst_n    (ARST_N),
		.push      (ale_fall),
		.push_addr (ad_dly[3]),
		.rd_idx    (stack_idx),
		.rd_data   (stack_data)
	); // [RQ24]

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	wire hit_stk = sel & ((addr == OFS_STACK_UPPER) |
		(addr == OFS_STACK_LOWER));
	wire [7:0] rd_mux = hit_a ? ctrl_a : hit_b ? ctrl_b :
		hit_stk ? stack_data : 8'h00;
	wire rd_drive = ~strb.rd_n & (hit_a | hit_b | hit_stk);

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			AD_OUT <= 8'h00;
			AD_OE  <= 1'b0;
		end
		else
		begin
			AD_OUT <= rd_mux;
			AD_OE  <= rd_drive;
		end
	end

	// ------------------------------------------------------------
	// Pins: power output, interrupt, option outputs
	// ------------------------------------------------------------
	// Power fail with selector zero floats the output
	wire pwr_drive = ~pwr_inactive &
		(VCC_GOOD | ctrl_b[B_PF_SEL]); // [RQ7] [RQ18] [RQ20]
	// Interrupt only with supply present
	wire irq_drive = VCC_GOOD & ((ram_clear_input_flag & ctrl_b[B_RAM_CLEAR_INPUT_IRQ]) |
		(wake_flag & wake_en) | (kick_flag & kick_en)); // [RQ19] [RQ21] [RQ25]

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			POWER_ON_OUT_OE    <= 1'b0;
			IRQ_OE             <= 1'b0;
			OSC_OUTPUT_ENABLE  <= 1'b1;
			AUX_BATTERY_ENABLE <= 1'b0;
			XTAL_LOAD_SELECT   <= 1'b0;
			RAM_CLEAR_START    <= 1'b0;
		end
		else
		begin
			POWER_ON_OUT_OE    <= pwr_drive; // [RQ20] [RQ21] [RQ22]
			IRQ_OE             <= irq_drive; // [RQ25]
			OSC_OUTPUT_ENABLE  <= ctrl_b[B_OSC_OUT]; // [RQ15]
			AUX_BATTERY_ENABLE <= ctrl_b[B_AUX_EN]; // [RQ14]
			XTAL_LOAD_SELECT   <= ctrl_b[B_XTAL_SEL]; // [RQ16]
			RAM_CLEAR_START    <= ram_clear_input_en & ram_clear_input_fall; // [RQ17]
		end
	end

endmodule

//--- src/rxc_pkg.sv
// Package of constants and carrier types for the extended control block
package rxc_pkg;

	// ------------------------------------------------------------
	// Register offsets within the second bank
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL_A      = 8'h4a;
	localparam logic [7:0] OFS_CTRL_B      = 8'h4b;
	localparam logic [7:0] OFS_STACK_UPPER = 8'h4e;
	localparam logic [7:0] OFS_STACK_LOWER = 8'h4f;
	localparam logic [7:0] OFS_XRAM_DATA   = 8'h53;
	localparam logic [7:0] OFS_PRIMARY_A   = 8'h0a;

	// ------------------------------------------------------------
	// Field positions, control register A
	// ------------------------------------------------------------
	localparam int A_AUX_VALID  = 7;
	localparam int A_UPDATE     = 6;
	localparam int A_BURST      = 5;
	localparam int A_PWR_INACT  = 4;
	localparam int A_RAM_CLR_F  = 3;
	localparam int A_WAKE_F     = 1;
	localparam int A_KICK_F     = 0;
	localparam logic [7:0] A_RESERVED_MASK = 8'h04;

	// ------------------------------------------------------------
	// Field positions, control register B
	// ------------------------------------------------------------
	localparam int B_AUX_EN     = 7;
	localparam int B_OSC_OUT    = 6;
	localparam int B_XTAL_SEL   = 5;
	localparam int B_RAM_CLEAR_INPUT_EN    = 4;
	localparam int B_PF_SEL     = 3;
	localparam int B_RAM_CLEAR_INPUT_IRQ   = 2;
	localparam int B_WAKE_EN    = 1;
	localparam int B_KICK_EN    = 0;
	localparam int BANK_SEL_BIT = 4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_CTRL_A = 8'h10;
	localparam logic [7:0] RST_CTRL_B = 8'h40;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ        = 200;
	localparam int UIP_LEAD_US    = 122;
	localparam int UIP_LEAD_CYC   = UIP_LEAD_US * CLK_MHZ;
	localparam int STACK_DEPTH    = 4;

	// Bus strobe samples carried together
	typedef struct packed {
		logic ale;
		logic rd_n;
		logic wr_n;
		logic cs_n;
	} rxc_strobe_s;

endpackage

//--- tb/rxc_ext_ctrl_asserts.sv
// Port-level checker for the extended control block
`timescale 1ns/1ps
module rxc_ext_ctrl_asserts
	import rxc_pkg::*;
#(
	parameter int XRAM_AW = 12
)(
	input wire logic               CLK,
	input wire logic               ARST_N,
	input wire logic               RD_N,
	input wire logic               WR_N,
	input wire logic               VCC_GOOD,
	input wire logic               XRAM_ADDR_LOAD,
	input wire logic [XRAM_AW-1:0] XRAM_ADDR_VAL,
	input wire logic [XRAM_AW-1:0] XRAM_ADDR,
	input wire logic               AD_OE,
	input wire logic               RAM_CLEAR_START,
	input wire logic               POWER_ON_OUT_OE,
	input wire logic               IRQ_OE,
	input wire logic               OSC_OUTPUT_ENABLE,
	input wire logic               AUX_BATTERY_ENABLE,
	input wire logic               XTAL_LOAD_SELECT
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	logic [4:0] wr_age;

	// Clocks since write was low; saturates so it never wraps
	always_ff @(posedge CLK or negedge ARST_N)
		if (!ARST_N)
			wr_age <= 5'h1f;
		else if (!WR_N)
			wr_age <= 5'h00;
		else if (wr_age != 5'h1f)
			wr_age <= wr_age + 5'h01;

	sequence s_load;
		XRAM_ADDR_LOAD ##1 1'b1;
	endsequence
	property p_reset_out;
		$rose(ARST_N) |-> OSC_OUTPUT_ENABLE && !POWER_ON_OUT_OE && !IRQ_OE;
	endproperty
	property p_read_drive;
		$rose(AD_OE) |-> !$past(RD_N, 4);
	endproperty
	property p_clear_pulse;
		RAM_CLEAR_START |=> !RAM_CLEAR_START;
	endproperty
	property p_xram_load;
		s_load |-> XRAM_ADDR == $past(XRAM_ADDR_VAL);
	endproperty
	property p_xram_step;
		$changed(XRAM_ADDR) && !$past(XRAM_ADDR_LOAD)
			|-> XRAM_ADDR == $past(XRAM_ADDR) + 1'b1;
	endproperty
	property p_irq_supply;
		$rose(IRQ_OE) |-> $past(VCC_GOOD);
	endproperty
	property p_irq_release;
		$fell(IRQ_OE) && VCC_GOOD |-> wr_age < 5'd16;
	endproperty
	property p_pwr_release;
		$fell(POWER_ON_OUT_OE) && $past(VCC_GOOD) && VCC_GOOD
			|-> wr_age < 5'd16;
	endproperty
	property p_cfg_write;
		$changed({OSC_OUTPUT_ENABLE, AUX_BATTERY_ENABLE, XTAL_LOAD_SELECT})
			|-> wr_age < 5'd16;
	endproperty

	a_reset_out: assert property (p_reset_out)
		else $error("outputs wrong after reset");
	a_read_drive: assert property (p_read_drive)
		else $error("bus driven without a read");
	a_clear_pulse: assert property (p_clear_pulse)
		else $error("ram clear start longer than one clock");
	a_xram_load: assert property (p_xram_load)
		else $error("ram address load lost");
	a_xram_step: assert property (p_xram_step)
		else $error("ram address stepped by other than one");
	a_irq_supply: assert property (p_irq_supply)
		else $error("interrupt driven without supply");
	a_irq_release: assert property (p_irq_release)
		else $error("interrupt released without a write");
	a_pwr_release: assert property (p_pwr_release)
		else $error("power output released without a write");
	a_cfg_write: assert property (p_cfg_write)
		else $error("config output changed without a write");
endmodule

bind rxc_ext_ctrl rxc_ext_ctrl_asserts #(.XRAM_AW(XRAM_AW)) i_asserts (
	.CLK(CLK), .ARST_N(ARST_N), .RD_N(RD_N), .WR_N(WR_N),
	.VCC_GOOD(VCC_GOOD), .XRAM_ADDR_LOAD(XRAM_ADDR_LOAD),
	.XRAM_ADDR_VAL(XRAM_ADDR_VAL), .XRAM_ADDR(XRAM_ADDR), .AD_OE(AD_OE),
	.RAM_CLEAR_START(RAM_CLEAR_START), .POWER_ON_OUT_OE(POWER_ON_OUT_OE),
	.IRQ_OE(IRQ_OE), .OSC_OUTPUT_ENABLE(OSC_OUTPUT_ENABLE),
	.AUX_BATTERY_ENABLE(AUX_BATTERY_ENABLE),
	.XTAL_LOAD_SELECT(XTAL_LOAD_SELECT)
);

//--- tb/rxc_ext_ctrl_test.sv
// Self-checking testbench for the extended control block
`timescale 1ns/1ps
module rxc_ext_ctrl_test
	import rxc_pkg::*;
;
	logic        CLK, ARST_N, AD_OE, ALE, RD_N, WR_N, CS_N, BANK_SELECT;
	logic        VCC_GOOD, AUX_BATTERY_OK, UPDATE_SOON, UPDATE_DONE;
	logic        WAKEUP_ALARM, KICKSTART_N, RAM_CLEAR_N, XRAM_ADDR_LOAD;
	logic        RAM_CLEAR_START, POWER_ON_OUT_OE, IRQ_OE, OSC_OUTPUT_ENABLE;
	logic        AUX_BATTERY_ENABLE, XTAL_LOAD_SELECT, ok, seen;
	logic        RAM_CLEAR_DONE = 1'b0;
	logic [7:0]  AD_IN, AD_OUT, q;
	logic [11:0] XRAM_ADDR_VAL, XRAM_ADDR;
	int          err_total, samples_checked;

	rxc_ext_ctrl i_dut (
		.CLK(CLK), .ARST_N(ARST_N), .AD_IN(AD_IN), .AD_OUT(AD_OUT),
		.AD_OE(AD_OE), .ALE(ALE), .RD_N(RD_N), .WR_N(WR_N), .CS_N(CS_N),
		.BANK_SELECT(BANK_SELECT), .VCC_GOOD(VCC_GOOD),
		.AUX_BATTERY_OK(AUX_BATTERY_OK), .UPDATE_SOON(UPDATE_SOON),
		.UPDATE_DONE(UPDATE_DONE), .WAKEUP_ALARM(WAKEUP_ALARM),
		.KICKSTART_N(KICKSTART_N), .RAM_CLEAR_N(RAM_CLEAR_N),
		.RAM_CLEAR_DONE(RAM_CLEAR_DONE), .XRAM_ADDR_LOAD(XRAM_ADDR_LOAD),
		.XRAM_ADDR_VAL(XRAM_ADDR_VAL), .XRAM_ADDR(XRAM_ADDR),
		.RAM_CLEAR_START(RAM_CLEAR_START), .POWER_ON_OUT_OE(POWER_ON_OUT_OE),
		.IRQ_OE(IRQ_OE), .OSC_OUTPUT_ENABLE(OSC_OUTPUT_ENABLE),
		.AUX_BATTERY_ENABLE(AUX_BATTERY_ENABLE),
		.XTAL_LOAD_SELECT(XTAL_LOAD_SELECT)
	);
	rxc_host_model i_host (
		.CLK(CLK), .AD_OUT(AD_OUT), .AD_OE(AD_OE), .AD_IN(AD_IN), .ALE(ALE),
		.RD_N(RD_N), .WR_N(WR_N), .CS_N(CS_N), .BANK_SELECT(BANK_SELECT)
	);

	// 200 MHz clock
	initial
	begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end

	// Compare, count and report
	task automatic chk(input string n, input logic [11:0] s,
		input logic [11:0] e);
		samples_checked++;
		if (s !== e)
		begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host.acc(1'b1, a, d, q, ok);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		i_host.acc(1'b0, a, 8'h00, q, ok);
		chk("read drive", ok, 1'b1);
		chk("read data", q, e);
	endtask
	task automatic print_verdict();
		$display("checks %0d, errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Reset values, config outputs, read-only and reserved bits
	task automatic t_regs();
		chk("osc out", OSC_OUTPUT_ENABLE, 1'b1);
		chk("pwr", POWER_ON_OUT_OE, 1'b0);
		rd(OFS_CTRL_A, 8'h90);
		rd(OFS_CTRL_B, RST_CTRL_B);
		wr(OFS_CTRL_B, 8'ha0);
		chk("aux en", AUX_BATTERY_ENABLE, 1'b1);
		chk("osc off", OSC_OUTPUT_ENABLE, 1'b0);
		chk("xtal", XTAL_LOAD_SELECT, 1'b1);
		rd(OFS_CTRL_B, 8'ha0);
		wr(OFS_CTRL_B, 8'h40);
		wr(OFS_CTRL_A, 8'h04);
		chk("pwr on", POWER_ON_OUT_OE, 1'b1);
		rd(OFS_CTRL_A, 8'h84);
		AUX_BATTERY_OK = 1'b0;
		rd(OFS_CTRL_A, 8'h04);
		AUX_BATTERY_OK = 1'b1;
		wr(OFS_CTRL_A, 8'h10);
		chk("pwr off", POWER_ON_OUT_OE, 1'b0);
		UPDATE_SOON = 1'b1;
		cyc(1);
		UPDATE_SOON = 1'b0;
		rd(OFS_CTRL_A, 8'hd0);
		UPDATE_DONE = 1'b1;
		cyc(1);
		UPDATE_DONE = 1'b0;
		rd(OFS_CTRL_A, 8'h90);
	endtask

	// Wake or kick event with its enable set or clear
	task automatic t_flag(input logic [7:0] en, input logic [7:0] fl,
		input logic kick);
		wr(OFS_CTRL_B, 8'h40 | en);
		{KICKSTART_N, WAKEUP_ALARM} = {!kick, !kick};
		cyc(4);
		{KICKSTART_N, WAKEUP_ALARM} = 2'b10;
		cyc(10);
		chk("irq", IRQ_OE, en != 8'h00);
		chk("pwr", POWER_ON_OUT_OE, en != 8'h00);
		rd(OFS_CTRL_A, 8'h80 | fl | (en != 8'h00 ? 8'h00 : 8'h10));
		wr(OFS_CTRL_A, 8'h10);
		chk("irq clear", IRQ_OE, 1'b0);
		chk("pwr clear", POWER_ON_OUT_OE, 1'b0);
	endtask

	// Host writes of one force each flag and the interrupt
	task automatic t_host_set();
		logic [7:0] fl [3] = '{8'h08, 8'h02, 8'h01};
		wr(OFS_CTRL_B, 8'h47);
		foreach (fl[i])
		begin
			wr(OFS_CTRL_A, 8'h10 | fl[i]);
			chk("forced irq", IRQ_OE, 1'b1);
			wr(OFS_CTRL_A, 8'h10);
			chk("irq gone", IRQ_OE, 1'b0);
		end
	endtask

	// Falling clear input, enabled then disabled
	task automatic t_clear(input logic [7:0] b, input logic en);
		wr(OFS_CTRL_B, b);
		RAM_CLEAR_N = 1'b0;
		seen = 1'b0;
		repeat (20)
		begin
			cyc(1);
			seen = seen | (RAM_CLEAR_START === 1'b1);
		end
		RAM_CLEAR_N = 1'b1;
		chk("clear start", seen, en);
		chk("clear irq", IRQ_OE, en);
		rd(OFS_CTRL_A, en ? 8'h98 : 8'h90);
		wr(OFS_CTRL_A, 8'h10);
	endtask

	// Wake with supply absent, then power fail select
	task automatic t_supply();
		wr(OFS_CTRL_B, 8'h4a);
		VCC_GOOD = 1'b0;
		WAKEUP_ALARM = 1'b1;
		cyc(10);
		chk("pwr no vcc", POWER_ON_OUT_OE, 1'b1);
		chk("irq no vcc", IRQ_OE, 1'b0);
		{VCC_GOOD, WAKEUP_ALARM} = 2'b10;
		cyc(6);
		chk("irq vcc back", IRQ_OE, 1'b1);
		wr(OFS_CTRL_B, 8'h42);
		VCC_GOOD = 1'b0;
		cyc(6);
		chk("pwr fail hiz", POWER_ON_OUT_OE, 1'b0);
		VCC_GOOD = 1'b1;
		wr(OFS_CTRL_A, 8'h10);
	endtask

	// Extended RAM address stepping across the top of its range
	task automatic t_burst();
		{XRAM_ADDR_LOAD, XRAM_ADDR_VAL} = {1'b1, 12'hffe};
		cyc(1);
		XRAM_ADDR_LOAD = 1'b0;
		wr(OFS_XRAM_DATA, 8'h5a);
		chk("no burst", XRAM_ADDR, 12'hffe);
		wr(OFS_CTRL_A, 8'h30);
		wr(OFS_XRAM_DATA, 8'ha5);
		chk("burst", XRAM_ADDR, 12'hfff);
		wr(OFS_XRAM_DATA, 8'h3c);
		chk("burst wrap", XRAM_ADDR, 12'h000);
		wr(OFS_CTRL_B, 8'h40);
		chk("other reg", XRAM_ADDR, 12'h000);
		wr(OFS_CTRL_A, 8'h10);
	endtask

	// Address stack, then an unmapped read that must stay undriven
	task automatic t_stack();
		wr(OFS_CTRL_B, 8'h40);
		wr(OFS_PRIMARY_A, 8'h20);
		rd(OFS_STACK_UPPER, OFS_CTRL_B);
		rd(OFS_STACK_LOWER, OFS_CTRL_B);
		i_host.acc(1'b0, 8'h60, 8'h00, q, ok);
		chk("unmapped", ok, 1'b0);
	endtask

	// Main sequence
	initial
	begin
		{ARST_N, UPDATE_SOON, UPDATE_DONE, WAKEUP_ALARM} = 4'h0;
		{KICKSTART_N, RAM_CLEAR_N, VCC_GOOD, AUX_BATTERY_OK} = 4'hf;
		{XRAM_ADDR_LOAD, XRAM_ADDR_VAL} = 13'h0000;
		err_total = 0;
		samples_checked = 0;
		cyc(4);
		ARST_N = 1'b1;
		cyc(6);
		t_regs();
		t_flag(8'h02, 8'h02, 1'b0);
		t_flag(8'h00, 8'h02, 1'b0);
		t_flag(8'h01, 8'h01, 1'b1);
		t_flag(8'h00, 8'h00, 1'b1);
		t_host_set();
		t_clear(8'h54, 1'b1);
		t_clear(8'h44, 1'b0);
		t_supply();
		t_burst();
		t_stack();
		print_verdict();
	end
endmodule

//--- tb/rxc_host_model.sv
// Host processor model driving the multiplexed address/data bus
`timescale 1ns/1ps
module rxc_host_model
	import rxc_pkg::*;
(
	input  wire logic       CLK,
	input  wire logic [7:0] AD_OUT,
	input  wire logic       AD_OE,
	output      logic [7:0] AD_IN,
	output      logic       ALE,
	output      logic       RD_N,
	output      logic       WR_N,
	output      logic       CS_N,
	output      logic       BANK_SELECT
);
	// Idle bus: address strobe low, read, write and select high, bank one not yet chosen
	initial
	begin
		AD_IN = 8'h00;
		{ALE, RD_N, WR_N, CS_N, BANK_SELECT} = 5'b01110;
	end

	// Phases last several clocks so the pin filter agrees on them
	task automatic step(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask

	// One bus cycle; a released bus shows the inverse, never the old value
	task automatic acc(input logic wr, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic ok);
		BANK_SELECT = 1'b1;
		{AD_IN, ALE} = {a, 1'b1};
		step(4);
		ALE = 1'b0;
		step(4);
		{AD_IN, CS_N, RD_N, WR_N} = {wr ? d : ~a, 1'b0, wr, !wr};
		{q, ok} = {8'h00, wr};
		repeat (12)
		begin
			step(1);
			if (!wr && !ok && AD_OE === 1'b1)
				{q, ok} = {AD_OUT, 1'b1};
		end
		{RD_N, WR_N} = 2'b11;
		// Chip select outlives the strobe so the commit still sees it
		step(8);
		{CS_N, AD_IN} = {1'b1, ~AD_IN};
		step(2);
	endtask
endmodule
